// >>> rtl/pdmc_map.svh
`ifndef PDMC_MAP_SVH
`define PDMC_MAP_SVH
// byte addresses of the wishbone registers
`define PDMC_ADDR_GCR      4'h0
`define PDMC_ADDR_MHRH     4'h4
`define PDMC_ADDR_MHRL     4'h8
`define PDMC_ADDR_STAT     4'hC
// global control register fields
`define PDMC_GCR_STANDBY_SELECT_BIT      7
`define PDMC_GCR_RAM_ENABLE_BIT      0
`define PDMC_GCR_RST       8'h09
// module halt register high
`define PDMC_MHRH_PSTOP    7
`define PDMC_MHRH_SER1     1
`define PDMC_MHRH_SER0     0
`define PDMC_MHRH_RST      8'h78
`define PDMC_MHRH_RO_MASK  8'h78
// module halt register low
`define PDMC_MHRL_T16      4
`define PDMC_MHRL_T8B      3
`define PDMC_MHRL_T8A      2
`define PDMC_MHRL_ADC      0
`define PDMC_MHRL_RST      8'h00
// module halt output vector positions
`define PDMC_HALT_T16      0
`define PDMC_HALT_T8A      1
`define PDMC_HALT_T8B      2
`define PDMC_HALT_SER0     3
`define PDMC_HALT_SER1     4
`define PDMC_HALT_ADC      5
`endif

// >>> rtl/pdmc_pkg.sv
package pdmc_pkg;
   typedef enum logic [1:0] {
      PDMC_RUN   = 2'b00,
      PDMC_SLEEP = 2'b01,
      PDMC_SSTBY = 2'b11,
      PDMC_HSTBY = 2'b10
   } pdmc_mode_e;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pdmc_wb_req_s;

   typedef struct packed {
      logic       clk_en;     // module clock runs
      logic       clk_stop;   // oscillator/system clock stopped
      logic       cpu_halt;
      logic       cpu_regs_undef;
      logic       ram_hold;
      logic       ports_hiz;
   } pdmc_ctl_s;
endpackage

// >>> rtl/pdmc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pdmc_sync
   import pdmc_pkg::*;
#(
   parameter int W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] async_i,
   input  wire logic [W-1:0] init_i,
   output logic      [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } pdmc_sync_s;
   pdmc_sync_s st_reg;
   pdmc_sync_s st_next;

   // level changes only when the 2nd and 3rd stages agree
   always_comb begin
      st_next     = st_reg;
      st_next.s1  = async_i;
      st_next.s2  = st_reg.s1;
      st_next.s3  = st_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.lvl[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.lvl ^ init_i;
endmodule // pdmc_sync
`default_nettype wire

// >>> rtl/pdmc_top.sv
// Overview of operation
// - three CPU power-down modes: sleep, soft, hard
// - any power-down mode halts the CPU
// - per-module halt bits; soft and hard standby halt all six modules
// - halt bit one: module halted and reset (MHRL T8A bit halts T8B, T8B bit halts T8A)
// - hardware standby: all halted, RAM held
// - clock pin behaviour only when configured
// - standby select picks sleep or software standby
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pdmc_map.svh"
module pdmc_top
   import pdmc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        sleep_req_i,
   input  wire logic        irq_any_i,
   input  wire logic        nmi_i,
   input  wire logic [2:0]  ext_irq_i,
   input  wire logic        hardware_standby_pin_n_i,
   input  wire logic        chip_init_pin_n_i,
   input  wire logic        clock_out_port_pin_sel_i,
   input  wire logic        sys_clk_i,
   output logic [1:0]       mode_o,
   output logic             cpu_halt_o,
   output logic             cpu_regs_undef_o,
   output logic             clk_stop_o,
   output logic             ram_hold_o,
   output logic             ram_enable_bit_o,
   output logic             ports_hiz_o,
   output logic [5:0]       module_halt_o,
   output logic [5:0]       module_reset_o,
   output logic             clk_pin_o,
   output logic             clk_pin_oe_o
);
   typedef struct packed {
      pdmc_mode_e mode;
      logic [7:0] gcr;
      logic [7:0] mhrh;
      logic [7:0] mhrl;
      logic       ack;
      logic [31:0] rdat;
   } pdmc_state_s;
   pdmc_state_s st_reg;
   pdmc_state_s st_next;

   logic [1:0] pin_lvl;
   logic       hardware_standby_pin_n;
   logic       init_n;
   logic       wb_hit;
   logic [7:0] wr_byte;
   logic       wake_sleep;
   logic       wake_soft;
   logic [5:0] halt_req;

   // pins are active low; sync starts at one so reset doesn't fake an edge
   pdmc_sync #(.W(2)) u_pin_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i (~{hardware_standby_pin_n_i, chip_init_pin_n_i}),
      .init_i  (2'b11),
      .level_o (pin_lvl)
   );
   assign hardware_standby_pin_n = pin_lvl[1];
   assign init_n = pin_lvl[0];

   assign wb_hit     = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign wr_byte    = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
   assign wake_sleep = irq_any_i || nmi_i || (|ext_irq_i);
   assign wake_soft  = nmi_i || (|ext_irq_i);

   always_comb begin
      st_next     = st_reg;
      st_next.ack = wb_hit;
      // register access; reserved high bits of the high halt reg read as one
      if (wb_hit && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            `PDMC_ADDR_GCR: begin
               st_next.gcr = wr_byte;
            end
            `PDMC_ADDR_MHRH: begin
               st_next.mhrh = wr_byte | `PDMC_MHRH_RO_MASK;
            end
            `PDMC_ADDR_MHRL: begin
               st_next.mhrl = wr_byte;
            end
            default: begin
            end
         endcase
      end
      if (wb_hit && !wb_we_i) begin
         case (wb_adr_i)
            `PDMC_ADDR_GCR:  st_next.rdat = {24'h000000, st_reg.gcr};
            `PDMC_ADDR_MHRH: st_next.rdat = {24'h000000, st_reg.mhrh};
            `PDMC_ADDR_MHRL: st_next.rdat = {24'h000000, st_reg.mhrl};
            `PDMC_ADDR_STAT: st_next.rdat = {30'h0000000, st_reg.mode};
            default:         st_next.rdat = 32'h00000000;
         endcase
      end
      // mode sequencing
      case (st_reg.mode)
         PDMC_RUN: begin
            if (sleep_req_i) begin
               if (st_reg.gcr[`PDMC_GCR_STANDBY_SELECT_BIT]) begin
                  st_next.mode = PDMC_SSTBY;
               end else begin
                  st_next.mode = PDMC_SLEEP;
               end
            end
         end
         PDMC_SLEEP: begin
            if (wake_sleep) begin
               st_next.mode = PDMC_RUN;
            end
         end
         PDMC_SSTBY: begin
            // select bit stays set after wake, software clears it
            if (wake_soft) begin
               st_next.mode = PDMC_RUN;
            end
         end
         PDMC_HSTBY: begin
            st_next.mode = PDMC_HSTBY;
         end
         default: begin
            st_next.mode = PDMC_RUN;
         end
      endcase
      // standby pin beats everything; registers reinitialised while in it
      if (!hardware_standby_pin_n) begin
         st_next.mode = PDMC_HSTBY;
         st_next.gcr  = `PDMC_GCR_RST;
         st_next.mhrh = `PDMC_MHRH_RST;
         st_next.mhrl = `PDMC_MHRL_RST;
      end else if (!init_n) begin
         st_next.mode = PDMC_RUN;
         st_next.gcr  = `PDMC_GCR_RST;
         st_next.mhrh = `PDMC_MHRH_RST;
         st_next.mhrl = `PDMC_MHRL_RST;
      end else if (st_reg.mode == PDMC_HSTBY) begin
         // leaving hardware standby goes through chip init
         st_next.mode = PDMC_HSTBY;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg.mode <= PDMC_RUN;
         st_reg.gcr  <= `PDMC_GCR_RST;
         st_reg.mhrh <= `PDMC_MHRH_RST;
         st_reg.mhrl <= `PDMC_MHRL_RST;
         st_reg.ack  <= 1'b0;
         st_reg.rdat <= 32'h00000000;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign halt_req[`PDMC_HALT_T16]  = st_reg.mhrl[`PDMC_MHRL_T16];
   assign halt_req[`PDMC_HALT_T8A]  = st_reg.mhrl[`PDMC_MHRL_T8B];
   assign halt_req[`PDMC_HALT_T8B]  = st_reg.mhrl[`PDMC_MHRL_T8A];
   assign halt_req[`PDMC_HALT_SER0] = st_reg.mhrh[`PDMC_MHRH_SER0];
   assign halt_req[`PDMC_HALT_SER1] = st_reg.mhrh[`PDMC_MHRH_SER1];
   assign halt_req[`PDMC_HALT_ADC]  = st_reg.mhrl[`PDMC_MHRL_ADC];

   // halted and reset for as long as the bit or a standby mode holds
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_halt
         assign module_halt_o[g]  = halt_req[g] || st_reg.mode == PDMC_SSTBY
                                    || st_reg.mode == PDMC_HSTBY;
         assign module_reset_o[g] = module_halt_o[g];
      end
   endgenerate

   assign wb_ack_o         = st_reg.ack;
   assign wb_dat_o         = st_reg.rdat;
   assign mode_o           = st_reg.mode;
   assign cpu_halt_o       = st_reg.mode != PDMC_RUN;
   assign cpu_regs_undef_o = st_reg.mode == PDMC_HSTBY;
   assign clk_stop_o       = st_reg.mode == PDMC_SSTBY || st_reg.mode == PDMC_HSTBY;
   assign ram_hold_o       = st_reg.mode != PDMC_RUN;
   assign ram_enable_bit_o = st_reg.gcr[`PDMC_GCR_RAM_ENABLE_BIT];
   assign ports_hiz_o      = st_reg.mode == PDMC_HSTBY;

   // clock pin: follows clock in run/sleep, high in soft standby, off in hard
   always_comb begin
      clk_pin_o    = 1'b0;
      clk_pin_oe_o = 1'b0;
      if (clock_out_port_pin_sel_i && !st_reg.mhrh[`PDMC_MHRH_PSTOP]) begin
         case (st_reg.mode)
            PDMC_RUN, PDMC_SLEEP: begin
               clk_pin_o    = sys_clk_i;
               clk_pin_oe_o = 1'b1;
            end
            PDMC_SSTBY: begin
               clk_pin_o    = 1'b1;
               clk_pin_oe_o = 1'b1;
            end
            default: begin
               clk_pin_o    = 1'b0;
               clk_pin_oe_o = 1'b0;
            end
         endcase
      end
   end
endmodule // pdmc_top
`default_nettype wire

// >>> bench/pdmc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pdmc_top_asserts
   import pdmc_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       sleep_req_i,
   input wire logic       irq_any_i,
   input wire logic       nmi_i,
   input wire logic       hardware_standby_pin_n_i,
   input wire logic       clock_out_port_pin_sel_i,
   input wire logic [1:0] mode_o,
   input wire logic       cpu_halt_o,
   input wire logic       cpu_regs_undef_o,
   input wire logic       clk_stop_o,
   input wire logic       ram_hold_o,
   input wire logic [5:0] module_halt_o,
   input wire logic [5:0] module_reset_o,
   input wire logic       clk_pin_o,
   input wire logic       clk_pin_oe_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_once: assert property (s_take |=> s_answer) else $error("ack missing or held");
   a_cpu_halted: assert property (cpu_halt_o == (mode_o != PDMC_RUN)) else $error("cpu halt wrong");
   a_mode_entry: assert property (mode_o == PDMC_RUN && sleep_req_i && ce_i && hardware_standby_pin_n_i
      |=> mode_o inside {PDMC_SLEEP, PDMC_SSTBY}) else $error("sleep not entered");
   a_sleep_wake: assert property (mode_o == PDMC_SLEEP && irq_any_i && ce_i
      |-> ##[1:2] mode_o == PDMC_RUN) else $error("sleep not left");
   a_soft_wake: assert property (mode_o == PDMC_SSTBY && nmi_i && ce_i
      |-> ##[1:2] mode_o == PDMC_RUN) else $error("standby not left");
   a_soft_state: assert property (mode_o == PDMC_SSTBY
      |-> clk_stop_o && module_halt_o == 6'h3F) else $error("soft standby state");
   a_soft_pin: assert property (mode_o == PDMC_SSTBY && clk_pin_oe_o |-> clk_pin_o) else $error("pin low");
   a_hard_state: assert property (mode_o == PDMC_HSTBY
      |-> cpu_regs_undef_o && ram_hold_o && module_reset_o == 6'h3F) else $error("hard standby state");
   a_hard_entry: assert property (!hardware_standby_pin_n_i [*6] |-> mode_o == PDMC_HSTBY) else $error("no hstby");
   a_pin_unused: assert property (!clock_out_port_pin_sel_i |-> !clk_pin_oe_o) else $error("pin driven");
   a_halt_resets: assert property (module_halt_o == module_reset_o) else $error("halt and reset differ");
endmodule // pdmc_top_asserts
bind pdmc_top pdmc_top_asserts u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_req_i,
   .irq_any_i, .nmi_i, .hardware_standby_pin_n_i, .clock_out_port_pin_sel_i, .mode_o, .cpu_halt_o,
   .cpu_regs_undef_o, .clk_stop_o, .ram_hold_o, .module_halt_o, .module_reset_o, .clk_pin_o, .clk_pin_oe_o);
`default_nettype wire

// >>> bench/power_down_mode_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", nm, e, s); end end
module power_down_mode_control_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [3:0]  adr   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [5:0]  ev    = 6'h00;
   logic        hs_n  = 1'b1;
   logic        ci_n  = 1'b1;
   logic        csel  = 1'b1;
   logic        sck   = 1'b0;
   logic        ce    = 1'b1;
   logic [3:0]  sel   = 4'h1;
   logic [1:0]  md;
   logic        chalt;
   logic        cstop;
   logic        ram_enable_bit;
   logic        hiz;
   logic [5:0]  mh;
   logic        cpin;
   logic        coe;
   logic [31:0] rdat;
   logic        ack;
   logic [31:0] ex;
   logic [31:0] v;
   logic [31:0] q[$];
   int          err_count = 0;
   int          n_tests   = 0;
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i) sck <= 1'($urandom);
   pdmc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_req_i(ev[0]),
      .irq_any_i(ev[1]), .nmi_i(ev[2]), .ext_irq_i(ev[5:3]), .hardware_standby_pin_n_i(hs_n),
      .chip_init_pin_n_i(ci_n), .clock_out_port_pin_sel_i(csel), .sys_clk_i(sck), .mode_o(md),
      .cpu_halt_o(chalt), .cpu_regs_undef_o(), .clk_stop_o(cstop), .ram_hold_o(), .ram_enable_bit_o(ram_enable_bit),
      .ports_hiz_o(hiz), .module_halt_o(mh), .module_reset_o(), .clk_pin_o(cpin), .clk_pin_oe_o(coe));
   // oldest expectation is matched against each read answer
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         ex = (q.size() > 0) ? q.pop_front() : 32'hFFFF_FFFF;
         `CHK("rdata", ex, rdat)
      end
   end
   task automatic conclude();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         conclude();
      end
      cyc <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic pls(input int b);
      @(posedge clk_i);
      ev <= 6'(6'h01 << b);
      @(posedge clk_i);
      ev <= 6'h00;
   endtask
   task automatic hold8();
      repeat (8) @(posedge clk_i);
   endtask
   initial begin
      v = $urandom(32'h6FEA5854);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h09);
      rd(4'h4, 32'h78);
      rd(4'h8, 32'h00);
      rd(4'hC, 32'h00);
      @(negedge clk_i);
      `CHK("run", {1'b1, 1'b0, 2'h0, 6'h00}, {ram_enable_bit, chalt, md, mh})
      @(posedge clk_i);
      wb(1'b1, 4'h2, 32'hFF);
      rd(4'h2, 32'h00);
      // a write with lane zero off must be ignored
      sel <= 4'hE;
      wb(1'b1, 4'h0, 32'h00);
      sel <= 4'h1;
      rd(4'h0, 32'h09);
      // frozen clock enable must swallow the sleep request
      ce <= 1'b0;
      pls(0);
      ce <= 1'b1;
      rd(4'hC, 32'h0);
      repeat (4) begin
         v = $urandom;
         wb(1'b1, 4'h8, v);
         rd(4'h8, {24'h0, v[7:0]});
         wb(1'b1, 4'h4, v);
         rd(4'h4, {24'h0, v[7:0] | 8'h78});
         @(negedge clk_i);
         `CHK("halt", {v[0], v[1], v[0], v[2], v[3], v[4]}, mh)
         @(posedge clk_i);
         csel <= v[8];
         @(negedge clk_i);
         `CHK("clkoe", v[8] & ~v[7], coe)
         `CHK("clkpin", (v[8] & ~v[7]) ? sck : 1'b0, cpin)
      end
      wb(1'b1, 4'h4, 32'h0);
      wb(1'b1, 4'h8, 32'h0);
      for (int s = 1; s < 6; s++) begin
         wb(1'b1, 4'h0, 32'h09);
         pls(0);
         rd(4'hC, 32'h1);
         @(negedge clk_i);
         `CHK("sleep", {1'b1, 6'h00, csel ? sck : 1'b0}, {chalt, mh, cpin})
         pls(s);
         rd(4'hC, 32'h0);
         wb(1'b1, 4'h0, 32'h89);
         pls(0);
         rd(4'hC, 32'h3);
         @(negedge clk_i);
         `CHK("soft", {1'b1, 6'h3F, csel}, {cstop, mh, cpin})
         pls(s);
         rd(4'hC, (s == 1) ? 32'h3 : 32'h0);
         if (s == 1) pls(2);
      end
      rd(4'h0, 32'h89);
      wb(1'b1, 4'h0, 32'h08);
      @(negedge clk_i);
      `CHK("ram_enable_bit", 1'b0, ram_enable_bit)
      @(posedge clk_i);
      hs_n <= 1'b0;
      hold8();
      rd(4'hC, 32'h2);
      @(negedge clk_i);
      `CHK("hard", {2'h2, 1'b1, 1'b1, 1'b0, 6'h3F}, {md, hiz, chalt, coe, mh})
      @(posedge clk_i);
      rd(4'h0, 32'h09);
      hs_n <= 1'b1;
      hold8();
      rd(4'hC, 32'h2);
      ci_n <= 1'b0;
      hold8();
      ci_n <= 1'b1;
      hold8();
      rd(4'hC, 32'h0);
      repeat (4) @(posedge clk_i);
      if (q.size() != 0) err_count++;
      conclude();
   end
endmodule // power_down_mode_control_bench
`default_nettype wire
